// ### common/sfe_pkg.sv
// shared constants for the safety status bank and its serial link
package sfe_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCLK_PERIOD_NS = 80;
    localparam logic [3:0] SCLK_HALF_CYC =
        4'(SCLK_PERIOD_NS / CLK_PERIOD_NS / 2);
    // frame layout: command, data, checksum, msb first
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [7:0] CMD_READ_FAULT_STATUS = 8'h01;
    localparam logic [7:0] CMD_READ_FRAME_STATUS = 8'h02;
    localparam logic [7:0] CMD_WRITE_FAULT_COUNTER = 8'h03;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    // safety_fault_counter_status fields
    localparam int FLT_CNT_LSB = 0;
    localparam int FLT_TIMEOUT_BIT = 4;
    localparam logic [3:0] FLT_CNT_RST = 4'h0;
    localparam logic [3:0] FLT_CNT_MAX = 4'hF;
    // serial_frame_error_status fields
    localparam int FRM_READBACK_BIT = 7;
    localparam int FRM_SHORT_BIT = 6;
    localparam int FRM_LONG_BIT = 5;
    localparam int FRM_BADCMD_BIT = 4;
    localparam int FRM_CRC_BIT = 3;
    localparam int FRM_CLK_FALL_BIT = 2;
    localparam int FRM_CLK_RISE_BIT = 1;
    localparam int FRM_RESET_BIT = 0;
    localparam logic [7:0] FRM_STATUS_RST = 8'h00;
    // host controller registers (byte addresses)
    localparam logic [31:0] HOST_CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] HOST_STAT_OFS = 32'h0000_0004;
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_DATA_LSB = 8;
    localparam int CTRL_CORRUPT_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RESP_LSB = 8;
endpackage : sfe_pkg

// ### common/sfe_spi_if.sv
// serial link between host controller and safety status device
`timescale 1ns/1ps
interface sfe_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic sdo_level;
    // released line reads low
    assign sdo_level = miso_oe ? miso : 1'b0;
    modport device (
        input sclk, cs_n, mosi, sdo_level,
        output miso, miso_oe
    );
    modport host (
        output sclk, cs_n, mosi,
        input sdo_level
    );
endinterface : sfe_spi_if

// ### design/sfe_crc8.sv
// checksum over command and data bytes
`timescale 1ns/1ps
module sfe_crc8 import sfe_pkg::*; (
    // data in
    input wire logic [15:0] data_i,
    // checksum out
    output logic [7:0] crc_o
);
    logic [7:0] c;
    always_comb begin
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ data_i[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_o = c;
    end
endmodule : sfe_crc8

// ### design/sfe_host.sv
// host controller: wishbone orders in, serial frames out
`timescale 1ns/1ps
module sfe_host import sfe_pkg::*; (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // link
    sfe_spi_if.host spi
);
    typedef enum {HST_IDLE, HST_LEAD, HST_SHIFT, HST_TRAIL, HST_GAP}
        sfe_host_st_e;
    sfe_host_st_e st_r;
    logic [16:0] ctrl_r;
    logic [7:0] resp_r;
    logic [23:0] tx_r;
    logic [7:0] rx_r;
    logic [3:0] half_r;
    logic [4:0] bits_r;
    logic sclk_r, cs_n_r, mosi_r;
    logic meta_r, miso_s_r;
    logic [7:0] crc;
    logic [15:0] cmd_data;
    logic req, wr_ctrl, start, tick, busy;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ctrl = req & wb_we_i & (wb_adr_i == HOST_CTRL_OFS);
    assign busy = (st_r != HST_IDLE);
    assign start = wr_ctrl & ~busy;
    assign tick = (half_r == SCLK_HALF_CYC - 4'h1);
    // wire order is command byte first, then data byte
    assign cmd_data = {ctrl_r[7:0], ctrl_r[15:8]};

    sfe_crc8 u_crc (
        .data_i(cmd_data),
        .crc_o(crc)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i && wb_adr_i == HOST_CTRL_OFS) begin
                wb_dat_o <= {15'h0000, ctrl_r};
            end else if (req && !wb_we_i && wb_adr_i == HOST_STAT_OFS) begin
                wb_dat_o <= {16'h0000, resp_r, 7'h00, busy};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // orders are refused while a frame runs
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r <= 17'h00000;
        end else if (start) begin
            if (wb_sel_i[0]) ctrl_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl_r[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) ctrl_r[16] <= wb_dat_i[CTRL_CORRUPT_BIT];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            miso_s_r <= 1'b0;
        end else begin
            meta_r <= spi.sdo_level;
            miso_s_r <= meta_r;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= HST_IDLE;
            half_r <= 4'h0;
            bits_r <= 5'h00;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            mosi_r <= 1'b0;
            tx_r <= 24'h000000;
            rx_r <= 8'h00;
            resp_r <= 8'h00;
        end else begin
            half_r <= (busy && !tick) ? half_r + 4'h1 : 4'h0;
            unique case (st_r)
                HST_IDLE: begin
                    if (start) begin
                        st_r <= HST_LEAD;
                    end
                end
                HST_LEAD: begin
                    cs_n_r <= 1'b0;
                    tx_r <= {cmd_data, crc ^ {7'h00, ctrl_r[16]}};
                    mosi_r <= cmd_data[15];
                    bits_r <= 5'h00;
                    if (tick) begin
                        st_r <= HST_SHIFT;
                    end
                end
                HST_SHIFT: begin
                    if (tick) begin
                        sclk_r <= ~sclk_r;
                        if (sclk_r) begin
                            // sample late in the bit, past the sync delay;
                            // only the leading byte carries the answer
                            if (bits_r < 5'h08) begin
                                rx_r <= {rx_r[6:0], miso_s_r};
                            end
                            tx_r <= {tx_r[22:0], 1'b0};
                            mosi_r <= tx_r[22];
                            bits_r <= bits_r + 5'h01;
                            if (bits_r == FRAME_BITS - 5'h01) begin
                                st_r <= HST_TRAIL;
                            end
                        end
                    end
                end
                HST_TRAIL: begin
                    if (bits_r == FRAME_BITS) begin
                        resp_r <= rx_r;
                        bits_r <= 5'h00;
                    end
                    if (tick) begin
                        cs_n_r <= 1'b1;
                        st_r <= HST_GAP;
                    end
                end
                HST_GAP: begin
                    if (tick) begin
                        st_r <= HST_IDLE;
                    end
                end
            endcase
        end
    end

    assign spi.sclk = sclk_r;
    assign spi.cs_n = cs_n_r;
    assign spi.mosi = mosi_r;
endmodule : sfe_host

// ### design/sfe_safety_status_dev.sv
// device end: fault counter status and frame error status
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - timeout sets flag, leaves diag, counts fault
// - timeout flag held until read clears
// - read clears only if cause gone
// - safe entry from diag/active counts one
// - no count from reset above hold limit
// - counter write: diag state, lock clear
// - counter at power-down limit: off until wake
// - counter bits 3-0, timeout bit 4
// - both registers init at reset, read
// - frame flags latch until read
// - frame flags describe previous frame
// - bit 7: output readback mismatch
// - bit 6: under 24 clock edges
// - bit 5: over 24 clock edges
// - bit 4: invalid or undefined command
// - bit 3: checksum mismatch
// - bit 2: clock high at select fall
// - bit 1: clock high at select rise
// - bit 0: frame cut by reset event
module sfe_safety_status_dev import sfe_pkg::*; (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // link
    sfe_spi_if.device spi,
    // device state events
    input wire logic diag_timeout_i,
    input wire logic safe_from_diag_i,
    input wire logic safe_from_active_i,
    input wire logic safe_from_reset_i,
    input wire logic in_diag_state_i,
    input wire logic cfg_lock_i,
    input wire logic wake_up_i,
    input wire logic reset_event_i,
    // limits
    input wire logic [3:0] safe_hold_limit_i,
    input wire logic [3:0] power_down_limit_i,
    // status out
    output logic diag_to_safe_o,
    output logic off_state_o,
    output logic [3:0] device_fault_counter_o,
    output logic [7:0] fault_status_o,
    output logic [7:0] frame_status_o
);
    // order: sdo level, mosi, cs_n, sclk
    logic [3:0] meta_r, sync_r, prev_r;
    logic sclk_s, cs_s, mosi_s, fb_s;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic in_frame_r, aborted_r, readback_err_r, clk_fall_err_r;
    logic [4:0] rise_cnt_r, fall_cnt_r;
    logic [23:0] rx_r, tx_r;
    logic miso_r, oe_r;
    logic [7:0] rd_data_r, frm_r, frm_set;
    logic to_flag_r, eq_prev_r, wake_prev_r;
    logic [3:0] cnt_r;
    logic [7:0] crc;
    logic eof, len_ok, crc_ok, cmd_ok, exec, rd_fault, rd_frame, wr_cnt;
    logic inc, eq;
    logic [7:0] cmd;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= 4'h2;
            sync_r <= 4'h2;
            prev_r <= 4'h2;
        end else begin
            meta_r <= {spi.sdo_level, spi.mosi, spi.cs_n, spi.sclk};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign sclk_s = sync_r[0];
    assign cs_s = sync_r[1];
    assign mosi_s = sync_r[2];
    assign fb_s = sync_r[3];
    assign sclk_rise = sclk_s & ~prev_r[0];
    assign sclk_fall = ~sclk_s & prev_r[0];
    assign cs_fall = ~cs_s & prev_r[1];
    assign cs_rise = cs_s & ~prev_r[1];

    sfe_crc8 u_crc (
        .data_i(rx_r[23:8]),
        .crc_o(crc)
    );

    // frame capture and edge counting
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_frame_r <= 1'b0;
            aborted_r <= 1'b0;
            readback_err_r <= 1'b0;
            clk_fall_err_r <= 1'b0;
            rise_cnt_r <= 5'h00;
            fall_cnt_r <= 5'h00;
            rx_r <= 24'h000000;
            tx_r <= 24'h000000;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (cs_fall) begin
            in_frame_r <= 1'b1;
            aborted_r <= 1'b0;
            readback_err_r <= 1'b0;
            clk_fall_err_r <= sclk_s;
            rise_cnt_r <= 5'h00;
            fall_cnt_r <= 5'h00;
            tx_r <= {rd_data_r, 16'h0000};
            miso_r <= rd_data_r[7];
            oe_r <= 1'b1;
        end else if (cs_rise) begin
            in_frame_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (in_frame_r) begin
            if (reset_event_i) begin
                aborted_r <= 1'b1;
            end
            if (sclk_rise) begin
                rx_r <= {rx_r[22:0], mosi_s};
                if (rise_cnt_r != 5'h1F) rise_cnt_r <= rise_cnt_r + 5'h01;
                if (miso_r != fb_s) readback_err_r <= 1'b1;
            end
            if (sclk_fall) begin
                if (fall_cnt_r != 5'h1F) fall_cnt_r <= fall_cnt_r + 5'h01;
                tx_r <= {tx_r[22:0], 1'b0};
                miso_r <= tx_r[22];
            end
        end
    end

    assign eof = cs_rise & in_frame_r;
    assign len_ok = (rise_cnt_r == FRAME_BITS) & (fall_cnt_r == FRAME_BITS);
    assign crc_ok = (crc == rx_r[7:0]);
    assign cmd = rx_r[23:16];
    assign cmd_ok = (cmd == CMD_READ_FAULT_STATUS) |
                    (cmd == CMD_READ_FRAME_STATUS) |
                    (cmd == CMD_WRITE_FAULT_COUNTER);
    assign exec = eof & len_ok & crc_ok & cmd_ok & ~aborted_r;
    assign rd_fault = exec & (cmd == CMD_READ_FAULT_STATUS);
    assign rd_frame = exec & (cmd == CMD_READ_FRAME_STATUS);

    always_comb begin
        frm_set = 8'h00;
        frm_set[FRM_READBACK_BIT] = eof & readback_err_r;
        frm_set[FRM_SHORT_BIT] = eof & ((rise_cnt_r < FRAME_BITS) |
                                        (fall_cnt_r < FRAME_BITS));
        frm_set[FRM_LONG_BIT] = eof & ((rise_cnt_r > FRAME_BITS) |
                                       (fall_cnt_r > FRAME_BITS));
        frm_set[FRM_BADCMD_BIT] = eof & len_ok & crc_ok & ~cmd_ok;
        frm_set[FRM_CRC_BIT] = eof & len_ok & ~crc_ok;
        frm_set[FRM_CLK_FALL_BIT] = eof & clk_fall_err_r;
        frm_set[FRM_CLK_RISE_BIT] = eof & sclk_s;
        frm_set[FRM_RESET_BIT] = in_frame_r & reset_event_i & ~aborted_r;
    end

    // sticky until read; set beats clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frm_r <= FRM_STATUS_RST;
        end else begin
            frm_r <= (frm_r & ~{8{rd_frame}}) | frm_set;
        end
    end

    // read data is returned in the next frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_r <= 8'h00;
        end else if (rd_fault) begin
            rd_data_r <= fault_status_o;
        end else if (rd_frame) begin
            rd_data_r <= frm_r;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            to_flag_r <= 1'b0;
            diag_to_safe_o <= 1'b0;
        end else begin
            to_flag_r <= (to_flag_r & ~rd_fault) | diag_timeout_i;
            diag_to_safe_o <= diag_timeout_i;
        end
    end

    // write gated by state and lock
    assign wr_cnt = exec & (cmd == CMD_WRITE_FAULT_COUNTER) &
                    in_diag_state_i & ~cfg_lock_i;
    // safe entries count; reset path gated
    assign inc = diag_timeout_i | safe_from_diag_i | safe_from_active_i |
                 (safe_from_reset_i & (cnt_r <= safe_hold_limit_i));

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= FLT_CNT_RST;
        end else if (wr_cnt) begin
            cnt_r <= rx_r[11:8];
        end else if (inc && cnt_r != FLT_CNT_MAX) begin
            // saturates so it never wraps below a limit
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // off on reaching limit, wake clears
    assign eq = (cnt_r == power_down_limit_i);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            off_state_o <= 1'b0;
            eq_prev_r <= 1'b0;
            wake_prev_r <= 1'b0;
        end else begin
            eq_prev_r <= eq;
            wake_prev_r <= wake_up_i;
            if (eq && !eq_prev_r) begin
                off_state_o <= 1'b1;
            end else if (wake_up_i && !wake_prev_r) begin
                off_state_o <= 1'b0;
            end
        end
    end

    assign fault_status_o = {3'h0, to_flag_r, cnt_r};
    assign device_fault_counter_o = cnt_r;
    assign frame_status_o = frm_r;
    assign spi.miso = miso_r;
    assign spi.miso_oe = oe_r;
endmodule : sfe_safety_status_dev

// ### verification/sfe_checker.sv
// assertions on the serial link between host and device
`timescale 1ns/1ps
module sfe_checker import sfe_pkg::*; (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    logic sclk_d_r;
    logic [5:0] rise_cnt_r;
    logic [5:0] fall_cnt_r;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
        end
    end

    // edge counts restart whenever select is high
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rise_cnt_r <= 6'h00;
            fall_cnt_r <= 6'h00;
        end else if (cs_n) begin
            rise_cnt_r <= 6'h00;
            fall_cnt_r <= 6'h00;
        end else begin
            rise_cnt_r <= rise_cnt_r + 6'(sclk && !sclk_d_r);
            fall_cnt_r <= fall_cnt_r + 6'(!sclk && sclk_d_r);
        end
    end

    AST_SCLK_LOW_AT_CS_FALL: assert property ($fell(cs_n) |-> !sclk)
        else $error("select fell with clock high");
    AST_SCLK_LOW_AT_CS_RISE: assert property ($rose(cs_n) |-> !sclk)
        else $error("select rose with clock high");
    AST_SCLK_IDLE_LOW: assert property (cs_n |-> !sclk)
        else $error("clock high outside frame");
    // lead phase plus first low half: nine sampled lows, then the rise
    AST_LEAD_TIME: assert property (
        $fell(cs_n) |-> !sclk [*8] ##1 !sclk ##1 sclk)
        else $error("first clock rise not after lead time");
    AST_HALF_PERIOD: assert property (
        $rose(sclk) |-> sclk [*5] ##1 !sclk)
        else $error("clock high phase not five cycles");
    AST_RISE_COUNT: assert property (
        $rose(cs_n) |-> rise_cnt_r == {1'b0, FRAME_BITS})
        else $error("frame rise count wrong");
    AST_FALL_COUNT: assert property (
        $rose(cs_n) |-> fall_cnt_r == {1'b0, FRAME_BITS})
        else $error("frame fall count wrong");
    AST_MOSI_HOLD: assert property (
        sclk && sclk_d_r |-> $stable(mosi))
        else $error("host data moved while clock high");
    AST_OE_OFF_IDLE: assert property (cs_n [*5] |-> !miso_oe)
        else $error("device drives data outside frame");

    cover property ($fell(cs_n));
    cover property ($rose(cs_n) ##[1:20] cs_n);
    cover property (miso_oe && miso);
endmodule : sfe_checker

// ### verification/testbench.sv
// self-checking bench for host controller and safety status device
`timescale 1ns/1ps
module testbench import sfe_pkg::*; ();
    typedef struct packed {
        logic [16:0] ctrl;
        logic diag;
        logic lock;
        logic [7:0] fs;
        logic [3:0] cnt;
        logic chk;
        logic [7:0] resp;
    } sfe_row_s;
    // ctrl is {corrupt, data, cmd}; resp is checked when chk is set
    sfe_row_s rows [10] = '{
        '{17'h00055, 1'h0, 1'h0, 8'h10, 4'h0, 1'h0, 8'h00},
        '{17'h00002, 1'h0, 1'h0, 8'h00, 4'h0, 1'h0, 8'h00},
        '{17'h00001, 1'h0, 1'h0, 8'h00, 4'h0, 1'h1, 8'h10},
        '{17'h00503, 1'h0, 1'h0, 8'h00, 4'h0, 1'h1, 8'h00},
        '{17'h00703, 1'h1, 1'h0, 8'h00, 4'h7, 1'h0, 8'h00},
        '{17'h00903, 1'h1, 1'h1, 8'h00, 4'h7, 1'h0, 8'h00},
        '{17'h10001, 1'h0, 1'h0, 8'h08, 4'h7, 1'h0, 8'h00},
        '{17'h00001, 1'h0, 1'h0, 8'h08, 4'h7, 1'h0, 8'h00},
        '{17'h00002, 1'h0, 1'h0, 8'h00, 4'h7, 1'h1, 8'h07},
        '{17'h00001, 1'h0, 1'h0, 8'h00, 4'h7, 1'h1, 8'h08}};
    logic core_clk_i;
    logic rst_i;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0] wb_sel;
    logic [31:0] wb_adr, wb_dat, wb_rd, wb_q;
    logic [3:0] ev, hold_lim, pwd_lim, dev_cnt;
    logic in_diag, cfg_lock, wake, rst_ev, to_safe, off_st;
    logic [7:0] fault_st, frame_st, frame_st2, last_resp;
    int err_count = 0;
    int compares = 0;
    sfe_spi_if spi();
    sfe_spi_if spi2();

    sfe_host u_sfe_host (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .spi(spi));
    sfe_safety_status_dev u_sfe_safety_status_dev (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .spi(spi), .diag_timeout_i(ev[3]),
        .safe_from_diag_i(ev[1]), .safe_from_active_i(ev[0]),
        .safe_from_reset_i(ev[2]), .in_diag_state_i(in_diag),
        .cfg_lock_i(cfg_lock), .wake_up_i(wake), .reset_event_i(rst_ev),
        .safe_hold_limit_i(hold_lim), .power_down_limit_i(pwd_lim),
        .diag_to_safe_o(to_safe), .off_state_o(off_st),
        .device_fault_counter_o(dev_cnt), .fault_status_o(fault_st),
        .frame_status_o(frame_st));
    // second device faces a bench driver that breaks the link rules
    sfe_safety_status_dev u_sfe_safety_status_dev_b (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .spi(spi2), .diag_timeout_i(ev[3]),
        .safe_from_diag_i(ev[1]), .safe_from_active_i(ev[0]),
        .safe_from_reset_i(ev[2]), .in_diag_state_i(in_diag),
        .cfg_lock_i(cfg_lock), .wake_up_i(wake), .reset_event_i(rst_ev),
        .safe_hold_limit_i(hold_lim), .power_down_limit_i(pwd_lim),
        .diag_to_safe_o(), .off_state_o(), .device_fault_counter_o(),
        .fault_status_o(), .frame_status_o(frame_st2));
    sfe_checker u_sfe_checker (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .sclk(spi.sclk), .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(spi.miso),
        .miso_oe(spi.miso_oe));

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [7:0] seen,
            input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wb(input logic we, input logic [31:0] adr,
            input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            print_verdict();
        end
        q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge core_clk_i);
    endtask : wb

    task automatic end_frame();
        int n;
        n = 0;
        do begin
            wb(1'b0, HOST_STAT_OFS, 32'h0, wb_q);
            n++;
        end while (wb_q[STAT_BUSY_BIT] !== 1'b0 && n < 200);
        if (n >= 200) begin
            err_count++;
            print_verdict();
        end
        last_resp = wb_q[15:8];
        // device flags land a few cycles after select rises
        repeat (4) @(posedge core_clk_i);
    endtask : end_frame

    task automatic frame(input logic [16:0] ctrl);
        wb(1'b1, HOST_CTRL_OFS, {15'h0000, ctrl}, wb_q);
        end_frame();
    endtask : frame

    task automatic pulse(input logic [3:0] v);
        ev <= v;
        @(posedge core_clk_i);
        ev <= 4'h0;
        @(posedge core_clk_i);
    endtask : pulse

    task automatic bang(input int n, input logic hi_fall, input logic hi_rise);
        spi2.sclk <= hi_fall;
        repeat (2) @(posedge core_clk_i);
        spi2.cs_n <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        for (int i = 0; i < n; i++) begin
            spi2.sclk <= 1'b1;
            repeat (5) @(posedge core_clk_i);
            spi2.sclk <= 1'b0;
            repeat (5) @(posedge core_clk_i);
        end
        spi2.sclk <= hi_rise;
        repeat (5) @(posedge core_clk_i);
        spi2.cs_n <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        spi2.sclk <= 1'b0;
        repeat (10) @(posedge core_clk_i);
    endtask : bang

    initial begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        wb_sel = 4'hF;
        {ev, in_diag, cfg_lock, wake, rst_ev} = '0;
        hold_lim = 4'hF;
        pwd_lim = 4'hF;
        spi2.sclk = 1'b0;
        spi2.cs_n = 1'b1;
        spi2.mosi = 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        check("frame status init", frame_st, FRM_STATUS_RST);
        check("fault status init", fault_st, 8'h00);
        wb(1'b0, 32'h0000_0010, 32'h0, wb_q);
        check("unmapped read", {7'h00, wb_q !== 32'h0}, 8'h00);
        foreach (rows[i]) begin
            in_diag <= rows[i].diag;
            cfg_lock <= rows[i].lock;
            frame(rows[i].ctrl);
            check("frame status", frame_st, rows[i].fs);
            check("counter", {4'h0, dev_cnt}, {4'h0, rows[i].cnt});
            if (rows[i].chk) begin
                check("response", last_resp, rows[i].resp);
            end
        end
        in_diag <= 1'b0;
        $display("test table done");
        pulse(4'h8);
        check("timeout to safe", {7'h00, to_safe}, 8'h01);
        check("timeout flag", fault_st, 8'h18);
        frame(17'h00001);
        check("flag cleared", fault_st, 8'h08);
        frame(17'h00001);
        check("read before clear", last_resp, 8'h18);
        $display("test timeout done");
        pulse(4'h1);
        pulse(4'h2);
        check("safe entries", {4'h0, dev_cnt}, 8'h0A);
        hold_lim <= 4'h4;
        pulse(4'h4);
        check("above hold limit", {4'h0, dev_cnt}, 8'h0A);
        hold_lim <= 4'hF;
        pulse(4'h4);
        check("below hold limit", {4'h0, dev_cnt}, 8'h0B);
        pwd_lim <= 4'hC;
        pulse(4'h1);
        @(posedge core_clk_i);
        check("off at limit", {7'h00, off_st}, 8'h01);
        wake <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        check("wake leaves off", {7'h00, off_st}, 8'h00);
        wake <= 1'b0;
        $display("test counter done");
        wb(1'b1, HOST_CTRL_OFS, 32'h0000_0002, wb_q);
        repeat (60) @(posedge core_clk_i);
        rst_ev <= 1'b1;
        @(posedge core_clk_i);
        rst_ev <= 1'b0;
        end_frame();
        check("reset cut", {7'h00, frame_st[FRM_RESET_BIT]}, 8'h01);
        bang(23, 1'b0, 1'b0);
        check("short", {7'h00, frame_st2[FRM_SHORT_BIT]}, 8'h01);
        bang(25, 1'b0, 1'b0);
        check("long", {7'h00, frame_st2[FRM_LONG_BIT]}, 8'h01);
        bang(24, 1'b1, 1'b0);
        check("clk fall", {7'h00, frame_st2[FRM_CLK_FALL_BIT]}, 8'h01);
        bang(24, 1'b0, 1'b1);
        check("clk rise", {7'h00, frame_st2[FRM_CLK_RISE_BIT]}, 8'h01);
        $display("test link faults done");
        rst_i <= 1'b1;
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check("frame status reset", frame_st, 8'h00);
        check("fault status reset", fault_st, 8'h00);
        check("off reset", {7'h00, off_st}, 8'h00);
        $display("test reset done");
        print_verdict();
    end
endmodule : testbench
